/* rtl/ssw_top.sv */
/*
 Supervisor core: watchdog on the shared select/kick pin, reset output
 generation with hold timer, lock decode and the serial link front end.
 Assumes clk is a free-running internal timebase, sck comes from the host,
 and the instruction decoder sits on the rx/tx user side.
*/
// Behaviour
// - Select high deselects the part and floats the serial output.
// - Deselected means standby, unless a nonvolatile write is still running.
// - Select low enables the part in active power mode.
// - Nothing is accepted until a falling select is seen after power-up.
// - Each falling edge of select/kick restarts the watchdog count from zero.
// - Watchdog enabled and no kick within the timeout asserts reset.
// - Read data leaves on the push-pull output, changing on falling sck.
// - Input bits arrive MSB first and are sampled on rising sck.
// - Protect pin plus lock bit freeze timeout and block-protect settings.
// - Reset output is open drain, polarity fixed per variant.
// - Low supply asserts reset; release only after 200 ms of good supply.
// - Reset is active from power-up and held 200 ms after supply is stable.
// - While reset is active, serial read and write requests are ignored.
// - Two nonvolatile bits choose the watchdog timeout.
// - Lock holds only with protect pin low and lock bit high.
module ssw_top #(
    parameter int unsigned TICK_CYCLES = ssw_pkg::TICK_CYCLES,
    parameter int unsigned HOLD_MS = ssw_pkg::HOLD_MS,
    parameter int unsigned WD_LONG_MS = ssw_pkg::WD_LONG_MS,
    parameter int unsigned WD_MID_MS = ssw_pkg::WD_MID_MS,
    parameter int unsigned WD_SHORT_MS = ssw_pkg::WD_SHORT_MS,
    parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic select_and_kick_input,
    input wire logic si,
    input wire logic wp_n,
    input wire logic supply_low,
    output logic so_out,
    output logic so_oe,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic reset_active,
    output ssw_pkg::ssw_rx_s rx,
    output logic rx_valid,
    input wire logic [ssw_pkg::BYTE_W-1:0] tx_data,
    input wire logic tx_load,
    input wire logic timeout_select_hi,
    input wire logic timeout_select_lo,
    input wire logic lock_enable_bit,
    input wire logic nv_write_busy,
    output logic settings_locked,
    output logic active_mode
);

    // A change counts only once the second and third stages agree
    function automatic logic ssw_settle(input logic [1:0] late, input logic prev);
        return (late[0] == late[1]) ? late[1] : prev;
    endfunction : ssw_settle

    // Timebase domain: pin synchronisers
    logic [2:0] sel_sync;
    logic [2:0] wp_sync;
    logic [2:0] low_sync;
    logic [2:0] rx_tog_sync;
    logic sel_level;
    logic wp_level;
    logic low_level;
    logic rx_tog_level;
    logic next_sel_level;
    logic next_rx_tog_level;
    logic kick_fall;
    logic rx_tog;
    ssw_pkg::ssw_rx_s rx_hold;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_sync <= ssw_pkg::SEL_SYNC_RST;
            wp_sync <= ssw_pkg::WP_SYNC_RST;
            low_sync <= ssw_pkg::LOW_SYNC_RST;
            rx_tog_sync <= ssw_pkg::TOG_SYNC_RST;
        end else begin
            sel_sync <= {sel_sync[1:0], select_and_kick_input};
            wp_sync <= {wp_sync[1:0], wp_n};
            low_sync <= {low_sync[1:0], supply_low};
            rx_tog_sync <= {rx_tog_sync[1:0], rx_tog};
        end
    end

    assign next_sel_level = ssw_settle(sel_sync[2:1], sel_level);
    assign next_rx_tog_level = ssw_settle(rx_tog_sync[2:1], rx_tog_level);
    assign kick_fall = sel_level & ~next_sel_level;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_level <= 1'b1;
            wp_level <= 1'b1;
            low_level <= 1'b0;
            rx_tog_level <= 1'b0;
        end else begin
            sel_level <= next_sel_level;
            wp_level <= ssw_settle(wp_sync[2:1], wp_level);
            low_level <= ssw_settle(low_sync[2:1], low_level);
            rx_tog_level <= next_rx_tog_level;
        end
    end

    // Link stays shut after power-up until the first select fall
    logic armed;
    // Sync stages show their reset value for three edges; only later is a high real,
    // so a pin held low from power-up cannot fake the arming fall
    logic [1:0] sel_fill;
    logic sel_seen_high;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_fill <= 2'h0;
            sel_seen_high <= 1'b0;
            armed <= 1'b0;
        end else begin
            if (sel_fill != 2'h3) begin
                sel_fill <= sel_fill + 2'h1;
            end
            if (sel_fill == 2'h3 && sel_sync[2:1] == 2'h3) begin
                sel_seen_high <= 1'b1;
            end
            if (kick_fall && sel_seen_high) begin
                armed <= 1'b1;
            end
        end
    end

    // Millisecond prescaler shared by hold and watchdog counters
    logic [ssw_pkg::TICK_W-1:0] pre_cnt;
    logic tick;
    logic tick_clear;
    ssw_pkg::ssw_rst_state_e state;
    ssw_pkg::ssw_rst_state_e next_state;
    logic [ssw_pkg::MS_W-1:0] hold_ms;
    logic [ssw_pkg::MS_W-1:0] wd_ms;
    logic [ssw_pkg::MS_W-1:0] wd_limit;
    logic wd_off;
    logic wd_expire;

    assign tick = (pre_cnt == ssw_pkg::TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || tick_clear || tick) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    always_comb begin
        wd_off = 1'b0;
        case ({timeout_select_hi, timeout_select_lo})
            ssw_pkg::WD_SEL_LONG: wd_limit = ssw_pkg::MS_W'(WD_LONG_MS);
            ssw_pkg::WD_SEL_MID: wd_limit = ssw_pkg::MS_W'(WD_MID_MS);
            ssw_pkg::WD_SEL_SHORT: wd_limit = ssw_pkg::MS_W'(WD_SHORT_MS);
            default: begin
                wd_limit = ssw_pkg::MS_W'(WD_LONG_MS);
                wd_off = 1'b1;
            end
        endcase
    end

    // A kick in the expiry cycle wins over the timeout
    assign wd_expire = (state == ssw_pkg::RST_RUN) && !wd_off && tick && !kick_fall
        && (wd_ms == wd_limit - 1'b1);

    always_comb begin
        next_state = state;
        case (state)
            ssw_pkg::RST_LOW: begin
                if (!low_level) begin
                    next_state = ssw_pkg::RST_HOLD;
                end
            end
            ssw_pkg::RST_HOLD: begin
                if (low_level) begin
                    next_state = ssw_pkg::RST_LOW;
                end else if (tick && hold_ms == ssw_pkg::MS_W'(HOLD_MS - 1)) begin
                    next_state = ssw_pkg::RST_RUN;
                end
            end
            ssw_pkg::RST_RUN: begin
                if (low_level) begin
                    next_state = ssw_pkg::RST_LOW;
                end else if (wd_expire) begin
                    next_state = ssw_pkg::RST_HOLD;
                end
            end
            default: next_state = ssw_pkg::RST_HOLD;
        endcase
    end

    // Kicks during reset leave the timers alone, so they cannot stretch the hold
    assign tick_clear = (next_state != state) || (kick_fall && state == ssw_pkg::RST_RUN);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ssw_pkg::RST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Hold restarts from zero on every entry, so low supply extends it
    always_ff @(posedge clk) begin
        if (!rst_n || state != ssw_pkg::RST_HOLD || tick_clear) begin
            hold_ms <= '0;
        end else if (tick) begin
            hold_ms <= hold_ms + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || state != ssw_pkg::RST_RUN || kick_fall || wd_off) begin
            wd_ms <= '0;
        end else if (tick) begin
            wd_ms <= wd_ms + 1'b1;
        end
    end

    // Open drain: only ever pulls low; the active-high variant releases
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reset_active <= 1'b1;
            reset_pin_oe <= !RESET_ACTIVE_HIGH;
            reset_pin_out <= 1'b0;
        end else begin
            reset_active <= (next_state != ssw_pkg::RST_RUN);
            reset_pin_oe <= RESET_ACTIVE_HIGH ? (next_state == ssw_pkg::RST_RUN)
                : (next_state != ssw_pkg::RST_RUN);
            reset_pin_out <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settings_locked <= 1'b0;
            active_mode <= 1'b0;
        end else begin
            settings_locked <= !wp_level && lock_enable_bit;
            active_mode <= !sel_level || nv_write_busy;
        end
    end

    // Link gate and received byte hand-off
    logic link_open;
    logic tx_tog;
    logic [ssw_pkg::BYTE_W-1:0] tx_hold;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_open <= 1'b0;
            rx <= '0;
            rx_valid <= 1'b0;
            tx_tog <= 1'b0;
            tx_hold <= '0;
        end else begin
            link_open <= armed && next_state == ssw_pkg::RST_RUN;
            rx_valid <= 1'b0;
            if (next_rx_tog_level != rx_tog_level && link_open) begin
                rx <= rx_hold;
                rx_valid <= 1'b1;
            end
            if (tx_load && link_open) begin
                tx_hold <= tx_data;
                tx_tog <= ~tx_tog;
            end
        end
    end

    // Serial clock domain, rising edge: input shifter
    logic [2:0] bit_cnt;
    logic [ssw_pkg::BYTE_W-2:0] shift_in;
    logic first_pending;

    always_ff @(posedge sck or posedge select_and_kick_input) begin
        if (select_and_kick_input) begin
            bit_cnt <= ssw_pkg::FIRST_BIT;
            shift_in <= '0;
            first_pending <= 1'b1;
        end else begin
            shift_in <= {shift_in[ssw_pkg::BYTE_W-3:0], si};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == ssw_pkg::LAST_BIT) begin
                first_pending <= 1'b0;
            end
        end
    end

    // Byte stays put for a whole byte time, long enough for the timebase
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold <= '0;
            rx_tog <= 1'b0;
        end else if (bit_cnt == ssw_pkg::LAST_BIT) begin
            rx_hold <= {first_pending, shift_in, si};
            rx_tog <= ~rx_tog;
        end
    end

    // Serial clock domain, falling edge: output shifter
    logic [2:0] tx_tog_sync;
    logic [2:0] link_sync;
    logic tx_tog_level;
    logic link_level;
    logic tx_seen;
    logic tx_pend;
    logic [ssw_pkg::BYTE_W-2:0] shift_out;

    always_ff @(negedge sck or negedge rst_n) begin
        if (!rst_n) begin
            tx_tog_sync <= ssw_pkg::TOG_SYNC_RST;
            link_sync <= ssw_pkg::TOG_SYNC_RST;
            tx_tog_level <= 1'b0;
            link_level <= 1'b0;
            tx_seen <= 1'b0;
        end else begin
            tx_tog_sync <= {tx_tog_sync[1:0], tx_tog};
            link_sync <= {link_sync[1:0], link_open};
            tx_tog_level <= ssw_settle(tx_tog_sync[2:1], tx_tog_level);
            link_level <= ssw_settle(link_sync[2:1], link_level);
            if (bit_cnt == ssw_pkg::FIRST_BIT) begin
                tx_seen <= tx_tog_level;
            end
        end
    end

    assign tx_pend = tx_tog_level != tx_seen;

    // Deselect floats the pin at once, without waiting for an sck edge
    always_ff @(negedge sck or posedge select_and_kick_input) begin
        if (select_and_kick_input) begin
            so_oe <= 1'b0;
            so_out <= 1'b0;
            shift_out <= '0;
        end else if (bit_cnt == ssw_pkg::FIRST_BIT && tx_pend) begin
            so_out <= tx_hold[ssw_pkg::BYTE_W-1];
            shift_out <= tx_hold[ssw_pkg::BYTE_W-2:0];
            so_oe <= link_level;
        end else begin
            so_out <= shift_out[ssw_pkg::BYTE_W-2];
            shift_out <= {shift_out[ssw_pkg::BYTE_W-3:0], 1'b0};
        end
    end

endmodule : ssw_top

/* inc/ssw_pkg.sv */
/*
 Shared constants and types of the select/kick watchdog supervisor.
 Assumes a 100 MHz internal timebase and a byte-wide serial link.
*/
package ssw_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_IN_NS = 1000000;
    // Internal timebase cycles per millisecond tick
    localparam int unsigned TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 17;
    localparam int unsigned HOLD_MS = 200;
    localparam int unsigned WD_LONG_MS = 1400;
    localparam int unsigned WD_MID_MS = 600;
    localparam int unsigned WD_SHORT_MS = 200;
    localparam int unsigned MS_W = 11;
    localparam logic [1:0] WD_SEL_LONG = 2'h0;
    localparam logic [1:0] WD_SEL_MID = 2'h1;
    localparam logic [1:0] WD_SEL_SHORT = 2'h2;
    localparam logic [1:0] WD_SEL_OFF = 2'h3;
    localparam int unsigned BYTE_W = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    // Reset values of pin synchronisers: select idles high, supply is good
    localparam logic [2:0] SEL_SYNC_RST = 3'h7;
    localparam logic [2:0] WP_SYNC_RST = 3'h7;
    localparam logic [2:0] LOW_SYNC_RST = 3'h0;
    localparam logic [2:0] TOG_SYNC_RST = 3'h0;

    typedef enum logic [1:0] {
        RST_LOW = 2'h0,
        RST_HOLD = 2'h1,
        RST_RUN = 2'h3
    } ssw_rst_state_e;

    typedef struct packed {
        logic first;
        logic [BYTE_W-1:0] data;
    } ssw_rx_s;
endpackage : ssw_pkg

/* dv/ssw_properties.sv */
/*
 Port checker for ssw_top: reset pin, supply, watchdog, lock and link rules.
 Assumes the bench's scaled counts: 10 clk per tick, 3 ms hold, 3 ms short timeout.
*/
module ssw_properties #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
    input logic clk,
    input logic rst_n,
    input logic select_and_kick_input,
    input logic supply_low,
    input logic wp_n,
    input logic lock_enable_bit,
    input logic nv_write_busy,
    input logic timeout_select_hi,
    input logic timeout_select_lo,
    input logic so_oe,
    input logic reset_pin_out,
    input logic reset_pin_oe,
    input logic reset_active,
    input logic rx_valid,
    input logic settings_locked,
    input logic active_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] idle;
    // Idle time on the short timeout only; saturates so it never wraps
    always_ff @(posedge clk) begin
        if (!rst_n || reset_active || !select_and_kick_input
            || {timeout_select_hi, timeout_select_lo} != 2'h2) begin
            idle <= 8'h0;
        end else if (idle != 8'hFF) begin
            idle <= idle + 8'h1;
        end
    end
    sequence s_drop;
        $rose(supply_low);
    endsequence
    sequence s_settled;
        reset_active == $past(reset_active, 2) && $stable(reset_active);
    endsequence
    od_low_a: assert property (reset_pin_out == 1'b0)
        else $error("reset pin data not low");
    pin_polarity_a: assert property (s_settled |->
        reset_pin_oe == (reset_active != RESET_ACTIVE_HIGH))
        else $error("reset pin enable wrong polarity");
    low_supply_a: assert property (s_drop |-> ##[1:6] reset_active)
        else $error("low supply did not assert reset");
    supply_hold_a: assert property (supply_low [*6] |-> reset_active)
        else $error("reset released under low supply");
    power_hold_a: assert property ($rose(rst_n) |-> reset_active [*8])
        else $error("power-up hold too short");
    no_rx_reset_a: assert property (reset_active && $past(reset_active) |-> !rx_valid)
        else $error("byte accepted while in reset");
    deselect_float_a: assert property (
        select_and_kick_input && $past(select_and_kick_input) |-> !so_oe)
        else $error("serial output driven while deselected");
    lock_decode_a: assert property (
        (rst_n && $stable({wp_n, lock_enable_bit})) [*8]
        |-> settings_locked == (!wp_n && lock_enable_bit))
        else $error("lock decode wrong");
    active_sel_a: assert property ((rst_n && !select_and_kick_input) [*6] |-> active_mode)
        else $error("selected but not active");
    standby_a: assert property (
        (select_and_kick_input && !nv_write_busy) [*6] |-> !active_mode)
        else $error("deselected but not in standby");
    wd_expire_a: assert property (idle == 8'd50 |-> reset_active)
        else $error("watchdog did not expire");
endmodule : ssw_properties

bind ssw_top ssw_properties #(.RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)) i_props (.*);

/* dv/ssw_host.sv */
/*
 Host model: serial link in mode 1,1 and watchdog kicks on the shared pin.
 Assumes the bench calls its tasks one at a time; serial clock 48 ns.
*/
module ssw_host (
    output logic sck,
    output logic select_and_kick_input,
    output logic si,
    input logic so_out,
    input logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;
    logic so_line;
    // A released line shows the inverse of its last value, never a held copy
    always @(so_out, so_oe) if (so_oe) last = so_out;
    assign so_line = so_oe ? so_out : !last;
    initial begin
        sck = 1'b1;
        select_and_kick_input = 1'b0;
        si = 1'b0;
    end
    task automatic sel(input logic v);
        select_and_kick_input = v;
    endtask : sel
    task automatic shift(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = b[i];
            #24;
            sck = 1'b1;
            r[i] = so_line;
            #24;
        end
        si = !si;
    endtask : shift
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input bit two,
                         output logic [7:0] r);
        select_and_kick_input = 1'b0;
        #30;
        shift(b0, r);
        if (two) shift(b1, r);
        #30;
        select_and_kick_input = 1'b1;
        #60;
    endtask : frame
    // Kicks come well inside the shortest timeout
    task automatic kick();
        select_and_kick_input = 1'b0;
        #60;
        select_and_kick_input = 1'b1;
        #90;
    endtask : kick
endmodule : ssw_host

/* dv/ssw_tb_top.sv */
/*
 Bench top: clock, reset, host model and scenarios for ssw_top.
 Assumes scaled ticks of 10 clk; the unscaled 1400 ms long timeout still takes 14000 cycles.
*/
module ssw_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    logic sck, select_and_kick_input, si, wp_n, supply_low, tx_load;
    logic timeout_select_hi, timeout_select_lo, lock_enable_bit, nv_write_busy;
    logic so_out, so_oe, reset_pin_out, reset_pin_oe, reset_active, rx_valid;
    logic settings_locked, active_mode;
    logic [7:0] tx_data;
    ssw_pkg::ssw_rx_s rx;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 32'h1E84;
    logic [8:0] got_q[$];
    always #5 clk = ~clk;
    always @(posedge clk) if (rx_valid) got_q.push_back(rx);
    ssw_top #(.TICK_CYCLES(10), .HOLD_MS(3), .WD_MID_MS(4),
              .WD_SHORT_MS(3)) i_dut (.*);
    ssw_host i_host (.*);
    function automatic int wd_ms(input int c);
        return c == 0 ? ssw_pkg::WD_LONG_MS : c == 1 ? 4 : 3;
    endfunction : wd_ms
    function automatic logic [8:0] pop();
        return got_q.size() > 0 ? got_q.pop_front() : 'x;
    endfunction : pop
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        #1;
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_rst(input logic v, input int lim, output int n);
        n = 0;
        while (reset_active !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            mismatches++;
            final_report();
        end
    endtask : wait_rst
    initial begin
        int n;
        logic [7:0] b, r;
        wp_n = 1'b1;
        supply_low = 1'b0;
        tx_load = 1'b0;
        tx_data = 8'h00;
        {timeout_select_hi, timeout_select_lo} = 2'h3;
        lock_enable_bit = 1'b0;
        nv_write_busy = 1'b0;
        // A real falling edge clears the serial-clock flops reset by rst_n, which never see clk
        #1;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (15) @(posedge clk);
        check(9'(reset_active), 9'h1);
        check(9'(reset_pin_oe), 9'h1);
        wait_rst(1'b0, 60, n);
        $display("power-up test done");
        // Select held low since power-up: no falling edge yet, so bytes are ignored
        i_host.shift(8'hA5, r);
        repeat (10) @(posedge clk);
        check(9'(got_q.size()), 9'h0);
        check(9'(active_mode), 9'h1);
        i_host.sel(1'b1);
        repeat (8) @(posedge clk);
        check(9'(active_mode), 9'h0);
        @(posedge clk) nv_write_busy <= 1'b1;
        repeat (4) @(posedge clk);
        check(9'(active_mode), 9'h1);
        @(posedge clk) nv_write_busy <= 1'b0;
        $display("select test done");
        for (int i = 0; i < 6; i++) begin
            b = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed));
            i_host.frame(b, ~b, i[0], r);
            check(pop(), {1'b1, b});
            if (i[0]) check(pop(), {1'b0, ~b});
        end
        $display("receive test done");
        for (int i = 0; i < 3; i++) begin
            b = 8'($random(seed));
            @(posedge clk) tx_data <= b;
            tx_load <= 1'b1;
            @(posedge clk) tx_load <= 1'b0;
            #1;
            i_host.frame(8'h03, 8'h00, 1'b1, r);
            check({1'b0, r}, {1'b0, b});
            check(9'(so_oe), 9'h0);
            got_q.delete();
        end
        $display("read test done");
        @(posedge clk) supply_low <= 1'b1;
        repeat (8) @(posedge clk);
        check(9'(reset_active), 9'h1);
        i_host.frame(8'h5A, 8'h00, 1'b0, r);
        check(9'(got_q.size()), 9'h0);
        @(posedge clk) supply_low <= 1'b0;
        repeat (15) @(posedge clk);
        check(9'(reset_active), 9'h1);
        wait_rst(1'b0, 60, n);
        $display("supply test done");
        @(posedge clk) {timeout_select_hi, timeout_select_lo} <= 2'h2;
        #1;
        for (int k = 0; k < 10; k++) begin
            i_host.kick();
            check(9'(reset_active), 9'h0);
        end
        for (int c = 0; c < 3; c++) begin
            @(posedge clk) {timeout_select_hi, timeout_select_lo} <= 2'(c);
            #1;
            i_host.kick();
            wait_rst(1'b1, 10 * wd_ms(c) + 30, n);
            check(9'(n >= 10 * wd_ms(c) - 25 && n <= 10 * wd_ms(c) - 5), 9'h1);
            wait_rst(1'b0, 60, n);
        end
        @(posedge clk) {timeout_select_hi, timeout_select_lo} <= 2'h3;
        $display("watchdog test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) wp_n <= i[0];
            lock_enable_bit <= i[1];
            repeat (10) @(posedge clk);
            check(9'(settings_locked), 9'(!i[0] && i[1]));
        end
        $display("lock test done");
        final_report();
    end
endmodule : ssw_tb_top
